// ### design/nma_arbiter.sv
// memory arbiter between contactless and two-wire host interfaces
`timescale 1ns/1ps

module nma_arbiter #(
    parameter int unsigned WDT_CYCLES = nma_pkg::WDT_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  nma_pkg::nma_cfg_s           cfg,
    input  nma_pkg::nma_rf_state_e      rf_state,
    input  nma_pkg::nma_rf_req_s        rf_req,
    input  wire logic                   rf_done,
    input  wire logic                   field_present,
    input  wire logic [15:0]            page_locked,
    input  nma_pkg::nma_host_req_s      host_req,
    input  wire logic                   message_flag_clear,
    output nma_pkg::nma_rf_ans_s        rf_ans,
    output logic                        host_ack,
    output logic                        host_nack,
    output logic                        host_lock_flag,
    output logic                        contactless_lock_flag,
    output logic                        message_read_flag,
    output logic [2:0]                  arbitration_status_register
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                 host_lock;
        logic                 rf_lock;
        logic                 msg_read;
        nma_pkg::nma_rf_ans_s rf_ans;
        logic                 host_ack;
        logic                 host_nack;
    } nma_arb_s;

    nma_arb_s st;
    nma_arb_s next_st;

    logic mir_hit;
    logic [3:0] mir_page;
    logic mir_ro;
    logic mir_auth;
    logic wdt_expired;

    logic rf_mem_cmd;
    logic rf_session;
    logic rf_invalid;
    logic rf_claim;
    logic host_claim;
    logic rf_allowed;
    logic last_page_hit;

    nma_mirror_map u_map (
        .cfg         (cfg),
        .page        (rf_req.page),
        .sector      (rf_req.sector),
        .page_locked (page_locked),
        .hit         (mir_hit),
        .buffer_page (mir_page),
        .read_only   (mir_ro),
        .needs_auth  (mir_auth)
    );

    nma_watchdog #(
        .CYCLES (WDT_CYCLES)
    ) u_wdt (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (st.host_lock),
        .expired  (wdt_expired)
    );

    // ****************************************************************
    // request classification
    // ****************************************************************
    always_comb begin
        rf_mem_cmd = rf_req.valid &&
                     (rf_req.cmd == nma_pkg::NMA_CMD_READ || rf_req.cmd == nma_pkg::NMA_CMD_WRITE);
        rf_session = (rf_req.sector == nma_pkg::SECTOR_ZERO) &&
                     (rf_req.page >= nma_pkg::SESS_PAGE_LO) && (rf_req.page <= nma_pkg::SESS_PAGE_HI);
        rf_invalid = (rf_req.sector == nma_pkg::SECTOR_ZERO) &&
                     (rf_req.page == nma_pkg::INV_PAGE_A || rf_req.page == nma_pkg::INV_PAGE_B);
        rf_allowed = rf_mem_cmd && !rf_invalid && !st.host_lock && !mir_auth &&
                     !(mir_ro && rf_req.cmd == nma_pkg::NMA_CMD_WRITE);
        rf_claim   = rf_allowed && !rf_session && !cfg.passthrough_enable;
        // address match while idle or halted
        host_claim = host_req.addr_match && !cfg.passthrough_enable && !st.rf_lock && !st.host_lock &&
                     (rf_state == nma_pkg::NMA_RF_IDLE || rf_state == nma_pkg::NMA_RF_HALT);
        last_page_hit = rf_allowed && rf_req.cmd == nma_pkg::NMA_CMD_READ &&
                        rf_req.sector == nma_pkg::SECTOR_ZERO && rf_req.page == cfg.last_message_block;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.rf_ans    = '0;
        next_st.host_ack  = 1'b0;
        next_st.host_nack = 1'b0;

        if (!field_present || (rf_req.valid && rf_req.cmd == nma_pkg::NMA_CMD_HALT) || rf_done) begin
            next_st.rf_lock = 1'b0;
        end
        if (host_req.unlock || host_req.stop || wdt_expired) begin
            next_st.host_lock = 1'b0;
        end

        if (rf_claim && field_present && !st.rf_lock) begin
            next_st.rf_lock = 1'b1;
        end else if (host_claim) begin
            next_st.host_lock = 1'b1;
        end

        // contactless answer: session reads, and sector select in the active state, pass a host lock
        if (rf_req.valid) begin
            if (rf_invalid) begin
                next_st.rf_ans.nak = 1'b1;
            end else if (rf_req.cmd == nma_pkg::NMA_CMD_SECTOR_SELECT) begin
                next_st.rf_ans.ack = (rf_state == nma_pkg::NMA_RF_ACTIVE) || !st.host_lock;
                next_st.rf_ans.nak = !next_st.rf_ans.ack;
            end else if (rf_mem_cmd && rf_session && rf_req.cmd == nma_pkg::NMA_CMD_READ) begin
                next_st.rf_ans.ack = 1'b1;
            end else if (rf_allowed) begin
                next_st.rf_ans.ack = 1'b1;
            end else if (rf_req.cmd != nma_pkg::NMA_CMD_HALT) begin
                next_st.rf_ans.nak = 1'b1;
            end
            next_st.rf_ans.to_buffer   = mir_hit && rf_allowed;
            next_st.rf_ans.buffer_page = mir_page;
            next_st.rf_ans.read_only   = mir_ro;
        end

        // register reads pass a contactless lock
        if (host_req.valid) begin
            if (st.rf_lock && !(host_req.is_register && !host_req.is_write)) begin
                next_st.host_nack = 1'b1;
            end else begin
                next_st.host_ack = 1'b1;
            end
        end

        // message end read, set beats clear
        if (message_flag_clear) begin
            next_st.msg_read = nma_pkg::FLAG_RESET;
        end
        if (last_page_hit) begin
            next_st.msg_read = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st           <= '0;
            st.host_lock <= nma_pkg::LOCK_RESET;
            st.rf_lock   <= nma_pkg::LOCK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign rf_ans                      = st.rf_ans;
    assign host_ack                    = st.host_ack;
    assign host_nack                   = st.host_nack;
    assign host_lock_flag              = st.host_lock;
    assign contactless_lock_flag       = st.rf_lock;
    assign message_read_flag           = st.msg_read;
    assign arbitration_status_register = {st.msg_read, st.host_lock, st.rf_lock};

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_one_owner;
        @(posedge core_clk) disable iff (reset) !(st.host_lock && st.rf_lock);
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("both locks set");

    property p_keep_rf;
        @(posedge core_clk) disable iff (reset)
            st.rf_lock && host_req.addr_match && !rf_done && field_present && !rf_req.valid |=> !st.host_lock;
    endproperty
    a_keep_rf: assert property (p_keep_rf) else $error("host took held memory");

    property p_host_set;
        @(posedge core_clk) disable iff (reset) host_claim && !rf_claim |=> st.host_lock;
    endproperty
    a_host_set: assert property (p_host_set) else $error("host lock not set");

    property p_field_loss;
        @(posedge core_clk) disable iff (reset) !field_present |=> !st.rf_lock;
    endproperty
    a_field_loss: assert property (p_field_loss) else $error("lock kept without field");

    property p_wdt;
        @(posedge core_clk) disable iff (reset) wdt_expired |=> !st.host_lock;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog did not release");

    property p_invalid_page;
        @(posedge core_clk) disable iff (reset) rf_req.valid && rf_invalid |=> rf_ans.nak && !rf_ans.ack;
    endproperty
    a_invalid_page: assert property (p_invalid_page) else $error("invalid page not refused");

    property p_host_block;
        @(posedge core_clk) disable iff (reset)
            st.host_lock && rf_mem_cmd && !rf_session |=> rf_ans.nak;
    endproperty
    a_host_block: assert property (p_host_block) else $error("memory given under host lock");

    property p_rf_block;
        @(posedge core_clk) disable iff (reset)
            st.rf_lock && host_req.valid && host_req.is_write |=> host_nack;
    endproperty
    a_rf_block: assert property (p_rf_block) else $error("host write under contactless lock");

    property p_msg;
        @(posedge core_clk) disable iff (reset) last_page_hit |=> message_read_flag;
    endproperty
    a_msg: assert property (p_msg) else $error("message flag not set");

    property p_reset_idle;
        @(posedge core_clk) $fell(reset) |-> arbitration_status_register == 3'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("status not idle after reset");

    property p_rf_set;
        @(posedge core_clk) disable iff (reset) rf_claim && field_present && !st.rf_lock |=> st.rf_lock;
    endproperty
    a_rf_set: assert property (p_rf_set) else $error("contactless lock not set");

    property p_rf_release;
        @(posedge core_clk) disable iff (reset)
            (rf_done || (rf_req.valid && rf_req.cmd == nma_pkg::NMA_CMD_HALT)) && !rf_claim |=> !st.rf_lock;
    endproperty
    a_rf_release: assert property (p_rf_release) else $error("contactless lock not released");

    property p_host_release;
        @(posedge core_clk) disable iff (reset) (host_req.stop || host_req.unlock) && !host_claim |=> !st.host_lock;
    endproperty
    a_host_release: assert property (p_host_release) else $error("host lock kept after release");

    property p_session_read;
        @(posedge core_clk) disable iff (reset)
            rf_req.valid && rf_session && rf_req.cmd == nma_pkg::NMA_CMD_READ |=> rf_ans.ack;
    endproperty
    a_session_read: assert property (p_session_read) else $error("session read refused");

    property p_sector_nak;
        @(posedge core_clk) disable iff (reset) rf_req.valid && rf_req.cmd == nma_pkg::NMA_CMD_SECTOR_SELECT &&
            st.host_lock && rf_state != nma_pkg::NMA_RF_ACTIVE |=> rf_ans.nak;
    endproperty
    a_sector_nak: assert property (p_sector_nak) else $error("sector select passed host lock");

    property p_reg_read;
        @(posedge core_clk) disable iff (reset)
            st.rf_lock && host_req.valid && host_req.is_register && !host_req.is_write |=> host_ack;
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("register read refused");

    property p_no_claim_pt;
        @(posedge core_clk) disable iff (reset)
            cfg.passthrough_enable && !st.rf_lock && !st.host_lock |=> !st.rf_lock && !st.host_lock;
    endproperty
    a_no_claim_pt: assert property (p_no_claim_pt) else $error("lock taken in pass-through");

    property p_mirror_ro;
        @(posedge core_clk) disable iff (reset)
            rf_req.valid && rf_req.cmd == nma_pkg::NMA_CMD_WRITE && mir_ro |=> rf_ans.nak;
    endproperty
    a_mirror_ro: assert property (p_mirror_ro) else $error("write to read only buffer page");

    property p_mirror_auth;
        @(posedge core_clk) disable iff (reset) rf_mem_cmd && !rf_session && mir_auth |=> rf_ans.nak;
    endproperty
    a_mirror_auth: assert property (p_mirror_auth) else $error("protected buffer without password");

endmodule

// ### design/nma_mirror_map.sv
// buffer mirror address map for the contactless view
`timescale 1ns/1ps

module nma_mirror_map (
    input  nma_pkg::nma_cfg_s cfg,
    input  wire logic [7:0]   page,
    input  wire logic [1:0]   sector,
    input  wire logic [15:0]  page_locked,  // lock state of overlaid blocks, per buffer page
    output logic              hit,
    output logic [3:0]        buffer_page,
    output logic              read_only,
    output logic              needs_auth
);

    logic [7:0] base;
    logic [7:0] offset;
    logic       active;

    // mirror only in non pass-through mode and with main supply
    always_comb begin
        base   = 8'(cfg.mirror_block * nma_pkg::MIRROR_BLOCK_PAGES);
        offset = 8'(page - base);
        active = cfg.mirror_enable && !cfg.passthrough_enable && cfg.vcc_present;
        hit         = active && (sector == nma_pkg::SECTOR_ZERO) && (page >= base)
                      && (offset < nma_pkg::MIRROR_PAGES);
        buffer_page = offset[3:0];
        read_only   = hit && page_locked[offset[3:0]];
        needs_auth  = hit && cfg.auth_enabled && cfg.buffer_password_protect && !cfg.authenticated;
    end

endmodule

// ### design/nma_pkg.sv
// package: shared constants and carrier structs of the memory arbiter
package nma_pkg;

    // ****************************************************************
    // page map of the contactless view
    // ****************************************************************
    localparam logic [7:0] INV_PAGE_A        = 8'hEA;
    localparam logic [7:0] INV_PAGE_B        = 8'hEB;
    localparam logic [7:0] SESS_PAGE_LO      = 8'hEC;
    localparam logic [7:0] SESS_PAGE_HI      = 8'hED;
    localparam logic [7:0] MIRROR_PAGES      = 8'h10;   // 64 byte buffer, 16 pages
    localparam logic [7:0] MIRROR_BLOCK_PAGES = 8'h04;  // pages per mirror block step
    localparam logic [1:0] SECTOR_ZERO       = 2'h0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic       LOCK_RESET        = 1'b0;
    localparam logic       FLAG_RESET        = 1'b0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned WDT_US           = 20_000;   // host watchdog, microseconds
    localparam int unsigned WDT_CYCLES       = (WDT_US / 1000) * (CLK_HZ / 1000);

    // ****************************************************************
    // contactless command classes
    // ****************************************************************
    typedef enum logic [2:0] {
        NMA_CMD_READ,
        NMA_CMD_WRITE,
        NMA_CMD_SECTOR_SELECT,
        NMA_CMD_HALT,
        NMA_CMD_OTHER
    } nma_cmd_e;

    // contactless state machine states as seen by the arbiter
    typedef enum logic [1:0] {
        NMA_RF_IDLE,
        NMA_RF_HALT,
        NMA_RF_ACTIVE,
        NMA_RF_AUTH
    } nma_rf_state_e;

    // contactless request carrier
    typedef struct packed {
        logic          valid;
        nma_cmd_e      cmd;
        logic [1:0]    sector;
        logic [7:0]    page;
    } nma_rf_req_s;

    // host request carrier
    typedef struct packed {
        logic          addr_match;   // own slave address after start
        logic          valid;        // read or write command
        logic          is_register;  // register read/write command
        logic          is_write;
        logic          stop;         // end of host sequence
        logic          unlock;       // host clears its lock bit
    } nma_host_req_s;

    // mirror and protection configuration
    typedef struct packed {
        logic          passthrough_enable;
        logic          mirror_enable;
        logic [7:0]    mirror_block;
        logic          auth_enabled;
        logic          buffer_password_protect;
        logic          authenticated;
        logic          vcc_present;
        logic [7:0]    last_message_block;
    } nma_cfg_s;

    // contactless answer
    typedef struct packed {
        logic          ack;
        logic          nak;
        logic          to_buffer;
        logic [3:0]    buffer_page;
        logic          read_only;
    } nma_rf_ans_s;

endpackage

// ### design/nma_watchdog.sv
// host lock watchdog: counts while the host holds memory
`timescale 1ns/1ps

module nma_watchdog #(
    parameter int unsigned CYCLES = nma_pkg::WDT_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      expired
);

    // refused at elaboration: the terminal count needs at least two states
    if (CYCLES < 2) begin : g_bad_cycles
        $error("watchdog count too small");
    end

    typedef struct packed {
        logic [31:0] count;
        logic        expired;
    } nma_wdt_s;

    nma_wdt_s st;
    nma_wdt_s next_st;

    // count up while held; expiry is a one-cycle pulse
    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        if (!run) begin
            next_st.count = 32'h0;
        end else if (st.count == 32'(CYCLES - 1)) begin
            next_st.count   = 32'h0;
            next_st.expired = 1'b1;
        end else begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.expired;

endmodule

// ### verification/nma_far_end.sv
// far side model: contactless front end and two-wire host controller
`timescale 1ns/1ps

module nma_far_end (
    input  wire logic              core_clk,
    output nma_pkg::nma_rf_req_s   rf_req,
    output logic                   rf_done,
    output nma_pkg::nma_host_req_s host_req
);
    // ************************************************************
    // frame drivers
    // ************************************************************
    initial begin
        rf_req = '0;
        rf_done = 1'b0;
        host_req = '0;
    end

    // one-cycle command; released lines show inverted data so no stale page looks valid
    task automatic rf_send(input nma_pkg::nma_cmd_e c, input logic [1:0] s, input logic [7:0] p);
        @(posedge core_clk);
        rf_req <= '{1'b1, c, s, p};
        @(posedge core_clk);
        rf_req <= '{1'b0, nma_pkg::NMA_CMD_OTHER, ~s, ~p};
    endtask

    task automatic host_send(input nma_pkg::nma_host_req_s h);
        @(posedge core_clk);
        host_req <= h;
        @(posedge core_clk);
        host_req <= '0;
    endtask

    // completion pulse of a contactless memory command
    task automatic rf_finish();
        @(posedge core_clk);
        rf_done <= 1'b1;
        @(posedge core_clk);
        rf_done <= 1'b0;
    endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the memory arbiter
`timescale 1ns/1ps

module tb;
    localparam int WDT = 24;
    logic                       core_clk;
    logic                       reset;
    logic                       field_present;
    logic                       message_flag_clear;
    logic                       rf_done;
    logic [15:0]                page_locked;
    nma_pkg::nma_cfg_s          cfg;
    nma_pkg::nma_rf_state_e     rf_state;
    nma_pkg::nma_rf_req_s       rf_req;
    nma_pkg::nma_host_req_s     host_req;
    nma_pkg::nma_rf_ans_s       rf_ans;
    logic                       host_ack;
    logic                       host_nack;
    logic                       host_lock_flag;
    logic                       contactless_lock_flag;
    logic                       message_read_flag;
    logic [2:0]                 arbitration_status_register;
    int                         err_count;
    int                         cmp_count;

    nma_arbiter #(.WDT_CYCLES(WDT)) u_dut (.core_clk, .reset, .cfg, .rf_state, .rf_req, .rf_done,
        .field_present, .page_locked, .host_req, .message_flag_clear, .rf_ans, .host_ack, .host_nack,
        .host_lock_flag, .contactless_lock_flag, .message_read_flag, .arbitration_status_register);

    nma_far_end u_far (.core_clk, .rf_req, .rf_done, .host_req);

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // expected answer to a read or write, hl = host holds memory
    function automatic nma_pkg::nma_rf_ans_s exp_ans(nma_pkg::nma_cmd_e c, logic [1:0] s, logic [7:0] p,
                                                     logic hl);
        nma_pkg::nma_rf_ans_s a;
        logic [7:0] base;
        logic [7:0] off;
        logic       sess;
        logic       bad;
        base = cfg.mirror_block * nma_pkg::MIRROR_BLOCK_PAGES;
        off = p - base;
        sess = s == nma_pkg::SECTOR_ZERO && (p == nma_pkg::SESS_PAGE_LO || p == nma_pkg::SESS_PAGE_HI);
        bad = s == nma_pkg::SECTOR_ZERO && (p == nma_pkg::INV_PAGE_A || p == nma_pkg::INV_PAGE_B);
        a = '0;
        a.to_buffer = cfg.mirror_enable && !cfg.passthrough_enable && cfg.vcc_present
                      && s == nma_pkg::SECTOR_ZERO && p >= base && off < nma_pkg::MIRROR_PAGES;
        a.buffer_page = off[3:0];
        a.read_only = a.to_buffer && page_locked[off[3:0]];
        // under host lock only session reads pass; a protected buffer refuses any access
        a.nak = bad || (hl && !(sess && c == nma_pkg::NMA_CMD_READ))
                || (a.to_buffer && c == nma_pkg::NMA_CMD_WRITE && a.read_only)
                || (a.to_buffer && cfg.auth_enabled && cfg.buffer_password_protect && !cfg.authenticated);
        a.ack = !a.nak;
        return a;
    endfunction

    // full contactless transfer: request, answer, completion
    task automatic rf_op(nma_pkg::nma_cmd_e c, logic [1:0] s, logic [7:0] p, logic hl);
        nma_pkg::nma_rf_ans_s e;
        e = exp_ans(c, s, p, hl);
        u_far.rf_send(c, s, p);
        @(negedge core_clk);
        check({rf_ans.ack, rf_ans.nak}, {e.ack, e.nak});
        if (e.ack) begin
            check(rf_ans.to_buffer, e.to_buffer);
        end
        if (e.ack && e.to_buffer) begin
            check({rf_ans.buffer_page, rf_ans.read_only}, {e.buffer_page, e.read_only});
        end
        u_far.rf_finish();
        @(negedge core_clk);
        check(contactless_lock_flag, 1'b0);
    endtask

    // ************************************************************
    // clock, watchdog and tests
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // the tests take a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        complete_run();
    end

    initial begin
        nma_pkg::nma_host_req_s h;
        logic [7:0]             p;
        reset = 1'b1;
        field_present = 1'b1;
        message_flag_clear = 1'b0;
        page_locked = 16'h0000;
        rf_state = nma_pkg::NMA_RF_IDLE;
        cfg = '0;
        cfg.vcc_present = 1'b1;
        cfg.mirror_block = 8'h01;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h0D18));
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check({rf_ans, host_ack, host_nack, host_lock_flag, contactless_lock_flag, message_read_flag,
               arbitration_status_register}, 16'h0000);
        // host claims memory, contactless side is limited meanwhile
        u_far.host_send(nma_pkg::nma_host_req_s'(6'h20));
        @(negedge core_clk);
        check(arbitration_status_register, 3'h2);
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h30, 1'b1);
        rf_op(nma_pkg::NMA_CMD_WRITE, 2'h0, nma_pkg::SESS_PAGE_HI, 1'b1);
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, nma_pkg::SESS_PAGE_LO, 1'b1);
        for (int i = 0; i < 2; i++) begin
            rf_state = i ? nma_pkg::NMA_RF_IDLE : nma_pkg::NMA_RF_ACTIVE;
            u_far.rf_send(nma_pkg::NMA_CMD_SECTOR_SELECT, 2'h1, 8'h00);
            @(negedge core_clk);
            check({rf_ans.ack, rf_ans.nak}, i ? 2'b01 : 2'b10);
        end
        u_far.host_send(nma_pkg::nma_host_req_s'(6'h02));
        @(negedge core_clk);
        check(host_lock_flag, 1'b0);
        // forgotten release is cut by the watchdog
        u_far.host_send(nma_pkg::nma_host_req_s'(6'h20));
        repeat (WDT / 2) @(negedge core_clk);
        check(host_lock_flag, 1'b1);
        for (int i = 0; i < WDT + 4 && host_lock_flag === 1'b1; i++) @(negedge core_clk);
        check(host_lock_flag, 1'b0);
        // contactless claims memory, host limited to register reads
        rf_state = nma_pkg::NMA_RF_ACTIVE;
        u_far.rf_send(nma_pkg::NMA_CMD_READ, 2'h0, 8'h30);
        @(negedge core_clk);
        check(arbitration_status_register, 3'h1);
        for (int i = 0; i < 4; i++) begin
            h = '0;
            h.valid = 1'b1;
            h.is_register = i[0];
            h.is_write = i[1];
            u_far.host_send(h);
            @(negedge core_clk);
            check({host_ack, host_nack}, i == 1 ? 2'b10 : 2'b01);
        end
        rf_state = nma_pkg::NMA_RF_IDLE;
        u_far.host_send(nma_pkg::nma_host_req_s'(6'h20));
        @(negedge core_clk);
        check(host_lock_flag, 1'b0);
        u_far.rf_send(nma_pkg::NMA_CMD_HALT, 2'h0, 8'h00);
        @(negedge core_clk);
        check(contactless_lock_flag, 1'b0);
        u_far.rf_send(nma_pkg::NMA_CMD_READ, 2'h0, 8'h40);
        @(negedge core_clk);
        check(contactless_lock_flag, 1'b1);
        field_present = 1'b0;
        @(negedge core_clk);
        check(contactless_lock_flag, 1'b0);
        field_present = 1'b1;
        // both sides claim in one cycle
        fork
            u_far.rf_send(nma_pkg::NMA_CMD_READ, 2'h0, 8'h30);
            u_far.host_send(nma_pkg::nma_host_req_s'(6'h20));
        join
        @(negedge core_clk);
        check({host_lock_flag, contactless_lock_flag}, 2'b01);
        u_far.rf_finish();
        @(negedge core_clk);
        // mirror edges at block 01h, then with pass-through and without main supply
        rf_state = nma_pkg::NMA_RF_ACTIVE;
        cfg.mirror_enable = 1'b1;
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h03, 1'b0);
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h04, 1'b0);
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h13, 1'b0);
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h14, 1'b0);
        cfg.passthrough_enable = 1'b1;
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h04, 1'b0);
        cfg.passthrough_enable = 1'b0;
        cfg.vcc_present = 1'b0;
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h05, 1'b0);
        // last message page read raises the flag, a clear pulse drops it
        cfg.last_message_block = 8'h20;
        rf_op(nma_pkg::NMA_CMD_READ, 2'h0, 8'h20, 1'b0);
        check(message_read_flag, 1'b1);
        message_flag_clear = 1'b1;
        @(negedge core_clk);
        message_flag_clear = 1'b0;
        check(message_read_flag, 1'b0);
        // random mirror traffic: block, locks, protection, supply, bad pages
        for (int n = 0; n < 60; n++) begin
            cfg = nma_pkg::nma_cfg_s'(22'($urandom));
            cfg.mirror_block = 8'($urandom_range(1, 20));
            cfg.passthrough_enable = ($urandom_range(0, 3) == 0);
            page_locked = 16'($urandom);
            p = cfg.mirror_block * nma_pkg::MIRROR_BLOCK_PAGES - 8'h02 + 8'($urandom_range(0, 19));
            if ($urandom_range(0, 7) == 0) begin
                p = nma_pkg::INV_PAGE_A + 8'($urandom_range(0, 1));
            end
            rf_op(nma_pkg::nma_cmd_e'(3'($urandom_range(0, 1))), 2'($urandom_range(0, 1)), p, 1'b0);
        end
        complete_run();
    end
endmodule
